/* File: core/fmpe_pkg.sv */
// Constants, field layout and types shared by the fault mask editor.
// Assumes a single 100 MHz clock domain with synchronous reset.
package fmpe_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_FREQ_MHZ = 100;
    localparam int unsigned HOLD_TIME_S = 2;
    localparam int unsigned HOLD_CYCLES =
        HOLD_TIME_S * CLK_FREQ_MHZ * 1000000;
    localparam int unsigned REPEAT_TIME_MS = 100;
    localparam int unsigned REPEAT_CYCLES =
        REPEAT_TIME_MS * CLK_FREQ_MHZ * 1000;

    // ------------------------------------------------------------
    // Buttons and fault lines
    // ------------------------------------------------------------
    localparam int BTN_N = 5;
    localparam int BTN_FN_UP = 0;
    localparam int BTN_FN_DN = 1;
    localparam int BTN_DT_UP = 2;
    localparam int BTN_DT_DN = 3;
    localparam int BTN_ENTER = 4;
    localparam logic [BTN_N-1:0] BTN_REPEAT_MASK = 5'h0C;

    localparam int FLT_N = 5;
    localparam int FLT_CONVERTER_FAULT = 0;
    localparam int FLT_LNA = 1;
    localparam int FLT_PA = 2;
    localparam int FLT_TEMP = 3;
    localparam int FLT_FAN = 4;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_FAULT = 4'h8;
    localparam int CTRL_KU_BIT = 0;
    localparam int STS_LNA = 0;
    localparam int STS_PA = 1;
    localparam int STS_TEMP = 2;
    localparam int STS_FAN = 3;
    localparam int STS_IF75 = 4;
    localparam int STS_PEND = 5;
    localparam int STS_FLASH = 6;
    localparam int STS_ERR = 7;
    localparam int STS_PRM_LSB = 8;

    // ------------------------------------------------------------
    // Reset values of stored settings
    // ------------------------------------------------------------
    localparam logic RST_LNA_EN = 1'h1;
    localparam logic RST_PA_EN = 1'h1;
    localparam logic RST_TEMP_EN = 1'h1;
    localparam logic RST_FAN_EN = 1'h1;
    localparam logic RST_IF75 = 1'h0;
    localparam logic RST_KU = 1'h0;

    typedef enum logic [2:0] {
        PRM_LNA,
        PRM_PA,
        PRM_TEMP,
        PRM_FAN,
        PRM_IFIMP
    } fmpe_param_e;

endpackage

/* File: core/fmpe_btn.sv */
// One controller button: synchroniser, press pulse, hold auto-repeat.
// Assumes an asynchronous level from the pin, active high.
`timescale 1ns/1ps
`default_nettype none
module fmpe_btn #(
    parameter int unsigned HOLD_CYC = 200000000,
    parameter int unsigned REP_CYC = 10000000,
    parameter bit REPEAT_EN = 1'b1
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic btn_in,
    output logic press
);
    localparam int CW = $clog2(HOLD_CYC + 1);

    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
        logic held;
        logic [CW-1:0] cnt;
        logic press;
    } fmpe_btn_s;

    fmpe_btn_s s_q;
    fmpe_btn_s s_d;

    always_comb begin
        s_d = s_q;
        s_d.s1 = btn_in;
        s_d.s2 = s_q.s1;
        s_d.prev = s_q.s2;
        s_d.press = 1'b0;
        if (s_q.s2 && !s_q.prev) begin
            s_d.press = 1'b1;
            s_d.cnt = '0;
            s_d.held = 1'b0;
        end else if (s_q.s2 && REPEAT_EN) begin
            // Hold delay first, then a steady repeat rate
            if (s_q.cnt == (s_q.held ? CW'(REP_CYC - 1)
                                     : CW'(HOLD_CYC - 1))) begin
                s_d.press = 1'b1;
                s_d.cnt = '0;
                s_d.held = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + CW'(1);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign press = s_q.press;

    chk_hold_repeat: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_q.s2 && s_q.prev && s_q.held && s_q.cnt == CW'(REP_CYC - 1)
        |=> press) else $error("held button did not repeat");

endmodule
`default_nettype wire

/* File: core/fmpe_mask.sv */
// Fault indicator gating from the stored enables and the band variant.
// Assumes raw fault and fan-present levels arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none
module fmpe_mask
    import fmpe_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [fmpe_pkg::FLT_N-1:0] fault_in,
    input wire logic fan_present_in,
    input wire logic ku,
    input wire logic lna_en,
    input wire logic pa_en,
    input wire logic temp_en,
    input wire logic fan_en,
    output logic [fmpe_pkg::FLT_N-1:0] led_fault,
    output logic alarm_pa,
    output logic alarm_temp
);
    typedef struct packed {
        logic [FLT_N-1:0] f1;
        logic [FLT_N-1:0] f2;
        logic p1;
        logic p2;
        logic [FLT_N-1:0] led;
        logic al_pa;
        logic al_temp;
    } fmpe_mask_s;

    fmpe_mask_s s_q;
    fmpe_mask_s s_d;

    always_comb begin
        s_d = s_q;
        s_d.f1 = fault_in;
        s_d.f2 = s_q.f1;
        s_d.p1 = fan_present_in;
        s_d.p2 = s_q.p1;
        s_d.led[FLT_CONVERTER_FAULT] = s_q.f2[FLT_CONVERTER_FAULT];
        s_d.led[FLT_LNA] = s_q.f2[FLT_LNA] & lna_en;
        s_d.led[FLT_PA] = s_q.f2[FLT_PA] & pa_en;
        s_d.led[FLT_TEMP] = s_q.f2[FLT_TEMP] & temp_en & pa_en;
        if (ku) begin
            // No fan setting here, only presence decides
            s_d.led[FLT_FAN] = s_q.f2[FLT_FAN] & s_q.p2;
        end else begin
            s_d.led[FLT_FAN] = s_q.f2[FLT_FAN] & fan_en & pa_en;
        end
        s_d.al_pa = s_q.f2[FLT_PA] & pa_en;
        s_d.al_temp = s_q.f2[FLT_TEMP] & temp_en & pa_en;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign led_fault = s_q.led;
    assign alarm_pa = s_q.al_pa;
    assign alarm_temp = s_q.al_temp;

    chk_converter_fault_unmasked: assert property (@(posedge core_clk) disable iff (!rst_n)
        ##1 led_fault[FLT_CONVERTER_FAULT] == $past(s_q.f2[FLT_CONVERTER_FAULT]))
        else $error("converter fault indicator was masked");
    chk_pa_off_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
        !pa_en |=> !led_fault[FLT_PA] && !led_fault[FLT_TEMP] && !alarm_pa
        && !alarm_temp) else $error("amplifier fault shown while off");
    chk_c_fan_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
        !ku && !pa_en |=> !led_fault[FLT_FAN])
        else $error("fan fault shown with amplifier off");
    chk_ku_nofan: assert property (@(posedge core_clk) disable iff (!rst_n)
        ku && !s_q.p2 |=> !led_fault[FLT_FAN])
        else $error("fan fault shown with no fan fitted");

endmodule
`default_nettype wire

/* File: core/fmpe_top.sv */
// Fault mask parameter editor: button-driven settings, display state,
// fault gating and an Avalon-MM slave for software access.
// Assumes button, fault and fan-present pins are asynchronous levels.
//
// Decided for this implementation: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
//
// Operation
// - C-band keeps separate enables for LNA, amplifier, temperature, fan.
// - The converter fault always shows and has no mask.
// - C-band amplifier disable forces fan enable off and hides its faults.
// - Ku-band keeps LNB, amplifier and temperature enables but no fan one.
// - Ku-band hides the fan fault when no fan is detected.
// - Ku-band amplifier disable hides its indicators and alarm outputs.
// - Each data button press toggles a selected enable's pending value.
// - The data field flashes while pending differs from stored.
// - Enter stores the pending value and stops the flashing.
// - C-band committing fan enabled with amplifier disabled is refused with error.
// - Leaving a parameter by function button drops the pending value.
// - Function up steps forward through parameters, down steps back.
// - IF impedance is either 50 or 75 ohms, set by data and enter.
// - Holding a data button over two seconds steps it repeatedly.
module fmpe_top
    import fmpe_pkg::*;
#(
    parameter int unsigned HOLD_CYC = fmpe_pkg::HOLD_CYCLES,
    parameter int unsigned REP_CYC = fmpe_pkg::REPEAT_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [fmpe_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [fmpe_pkg::BTN_N-1:0] btn_in,
    input wire logic [fmpe_pkg::FLT_N-1:0] fault_in,
    input wire logic fan_present_in,
    output logic [fmpe_pkg::FLT_N-1:0] led_fault,
    output logic alarm_pa,
    output logic alarm_temp,
    output logic [2:0] lcd_param,
    output logic lcd_value,
    output logic lcd_flash,
    output logic lcd_error
);
    import fmpe_pkg::*;

    typedef struct packed {
        fmpe_param_e prm;
        logic pend;
        logic lna_en;
        logic pa_en;
        logic temp_en;
        logic fan_en;
        logic if75;
        logic flash;
        logic err;
        logic ku;
        logic waitreq;
        logic [31:0] rdata;
    } fmpe_top_s;

    localparam fmpe_top_s TOP_RST = '{
        prm: PRM_LNA,
        pend: RST_LNA_EN,
        lna_en: RST_LNA_EN,
        pa_en: RST_PA_EN,
        temp_en: RST_TEMP_EN,
        fan_en: RST_FAN_EN,
        if75: RST_IF75,
        flash: 1'h0,
        err: 1'h0,
        ku: RST_KU,
        waitreq: 1'h1,
        rdata: 32'h0
    };

    fmpe_top_s s_q;
    fmpe_top_s s_d;
    logic [BTN_N-1:0] press;
    logic [FLT_N-1:0] led_w;
    logic fn_any;
    logic dt_any;
    logic fan_refuse;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic stored_of(fmpe_top_s s);
        logic v;
        v = 1'b0;
        case (s.prm)
            PRM_LNA: v = s.lna_en;
            PRM_PA: v = s.pa_en;
            PRM_TEMP: v = s.temp_en;
            PRM_FAN: v = s.fan_en;
            PRM_IFIMP: v = s.if75;
            default: v = 1'b0;
        endcase
        return v;
    endfunction

    // Ku-band has no fan setting, so that stop is skipped
    function automatic fmpe_param_e step(fmpe_param_e p, logic up, logic ku);
        fmpe_param_e n;
        n = p;
        case (p)
            PRM_LNA: n = up ? PRM_PA : PRM_IFIMP;
            PRM_PA: n = up ? PRM_TEMP : PRM_LNA;
            PRM_TEMP: n = up ? (ku ? PRM_IFIMP : PRM_FAN) : PRM_PA;
            PRM_FAN: n = up ? PRM_IFIMP : PRM_TEMP;
            PRM_IFIMP: n = up ? PRM_LNA : (ku ? PRM_TEMP : PRM_FAN);
            default: n = PRM_LNA;
        endcase
        return n;
    endfunction

    // ------------------------------------------------------------
    // Buttons
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < BTN_N; gi++) begin : g_btn
            fmpe_btn #(
                .HOLD_CYC(HOLD_CYC),
                .REP_CYC(REP_CYC),
                .REPEAT_EN(BTN_REPEAT_MASK[gi])
            ) u_btn (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .btn_in(btn_in[gi]),
                .press(press[gi])
            );
        end
    endgenerate

    assign fn_any = press[BTN_FN_UP] | press[BTN_FN_DN];
    assign dt_any = press[BTN_DT_UP] | press[BTN_DT_DN];
    // Ku-band has no fan setting, so a stranded fan stop is never refused
    assign fan_refuse = (s_q.prm == PRM_FAN) && s_q.pend && !s_q.pa_en
                        && !s_q.ku;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;

        // Function buttons win over data, data over enter
        if (fn_any) begin
            s_d.prm = step(s_q.prm, press[BTN_FN_UP], s_q.ku);
            s_d.pend = stored_of(s_d);
            s_d.err = 1'b0;
        end else if (dt_any) begin
            // Every parameter here is two-valued
            s_d.pend = ~s_q.pend;
            s_d.err = 1'b0;
        end else if (press[BTN_ENTER]) begin
            if (fan_refuse) begin
                s_d.err = 1'b1;
                s_d.pend = s_q.fan_en;
            end else begin
                case (s_q.prm)
                    PRM_LNA: s_d.lna_en = s_q.pend;
                    PRM_PA: begin
                        s_d.pa_en = s_q.pend;
                        if (!s_q.pend && !s_q.ku) begin
                            s_d.fan_en = 1'b0;
                        end
                    end
                    PRM_TEMP: s_d.temp_en = s_q.pend;
                    PRM_FAN: begin
                        // Left stranded here by a band change
                        if (!s_q.ku) begin
                            s_d.fan_en = s_q.pend;
                        end else begin
                            s_d.pend = s_q.fan_en;
                        end
                    end
                    PRM_IFIMP: s_d.if75 = s_q.pend;
                    default: s_d.pend = s_q.pend;
                endcase
            end
        end

        s_d.flash = (s_d.pend != stored_of(s_d));

        // Avalon slave: one wait cycle, answer on the next edge
        if ((avs_read || avs_write) && s_q.waitreq) begin
            s_d.waitreq = 1'b0;
            s_d.rdata = 32'h0;
            if (avs_address == ADDR_CTRL) begin
                s_d.rdata[CTRL_KU_BIT] = s_q.ku;
            end else if (avs_address == ADDR_STATUS) begin
                s_d.rdata[STS_LNA] = s_q.lna_en;
                s_d.rdata[STS_PA] = s_q.pa_en;
                s_d.rdata[STS_TEMP] = s_q.temp_en;
                s_d.rdata[STS_FAN] = s_q.fan_en;
                s_d.rdata[STS_IF75] = s_q.if75;
                s_d.rdata[STS_PEND] = s_q.pend;
                s_d.rdata[STS_FLASH] = s_q.flash;
                s_d.rdata[STS_ERR] = s_q.err;
                s_d.rdata[STS_PRM_LSB +: 3] = s_q.prm;
            end else if (avs_address == ADDR_FAULT) begin
                s_d.rdata[FLT_N-1:0] = led_w;
            end
        end else begin
            s_d.waitreq = 1'b1;
        end
        if (avs_write && !s_q.waitreq && avs_address == ADDR_CTRL) begin
            s_d.ku = avs_writedata[CTRL_KU_BIT];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_q <= TOP_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Fault gating
    // ------------------------------------------------------------
    fmpe_mask u_mask (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .fault_in(fault_in),
        .fan_present_in(fan_present_in),
        .ku(s_q.ku),
        .lna_en(s_q.lna_en),
        .pa_en(s_q.pa_en),
        .temp_en(s_q.temp_en),
        .fan_en(s_q.fan_en),
        .led_fault(led_w),
        .alarm_pa(alarm_pa),
        .alarm_temp(alarm_temp)
    );

    assign led_fault = led_w;
    assign avs_readdata = s_q.rdata;
    assign avs_waitrequest = s_q.waitreq;
    assign lcd_param = s_q.prm;
    assign lcd_value = s_q.pend;
    assign lcd_flash = s_q.flash;
    assign lcd_error = s_q.err;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_toggle_data: assert property (@(posedge core_clk) disable iff (!rst_n)
        dt_any && !fn_any |=> lcd_value != $past(lcd_value))
        else $error("data press did not toggle pending value");
    chk_flash_diff: assert property (@(posedge core_clk) disable iff (!rst_n)
        lcd_flash == (s_q.pend != stored_of(s_q)))
        else $error("flash does not match pending versus stored");
    chk_enter_commit: assert property (@(posedge core_clk) disable iff (!rst_n)
        press[BTN_ENTER] && !fn_any && !dt_any && !fan_refuse
        |=> !lcd_flash) else $error("enter left the field flashing");
    chk_fan_reject: assert property (@(posedge core_clk) disable iff (!rst_n)
        press[BTN_ENTER] && !fn_any && !dt_any && fan_refuse
        |=> lcd_error && !s_q.fan_en)
        else $error("fan enable accepted with amplifier off");
    chk_fn_discard: assert property (@(posedge core_clk) disable iff (!rst_n)
        fn_any |=> !lcd_flash && $stable(s_q.lna_en) && $stable(s_q.if75))
        else $error("function press kept a pending value");
    chk_fn_up_step: assert property (@(posedge core_clk) disable iff (!rst_n)
        press[BTN_FN_UP] && s_q.prm == PRM_LNA |=> lcd_param == PRM_PA)
        else $error("function up did not advance");
    chk_fan_forced: assert property (@(posedge core_clk) disable iff (!rst_n)
        press[BTN_ENTER] && !fn_any && !dt_any && s_q.prm == PRM_PA
        && !s_q.pend && !s_q.ku |=> !s_q.fan_en)
        else $error("fan enable survived amplifier disable");
    chk_bus_answer: assert property (@(posedge core_clk) disable iff (!rst_n)
        (avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one cycle after request");

endmodule
`default_nettype wire

/* File: dv/fmpe_hhc.sv */
// Behavioural hand-held controller: presses and releases the buttons.
// Assumes the bench calls press() from its main sequence only.
`timescale 1ns/1ps
`default_nettype none
module fmpe_hhc
    import fmpe_pkg::*;
(
    input wire logic core_clk,
    output var logic [fmpe_pkg::BTN_N-1:0] btn_in
);
    import fmpe_pkg::*;
    initial btn_in = '0;
    // One button at a time, always released long enough
    // for the synchronisers to see the gap between presses
    task automatic press(input int idx, input int hold);
        begin
            @(posedge core_clk);
            btn_in[idx] <= 1'b1;
            repeat (hold) @(posedge core_clk);
            btn_in[idx] <= 1'b0;
            repeat (8) @(posedge core_clk);
        end
    endtask
endmodule
`default_nettype wire

/* File: dv/fmpe_top_tb.sv */
// Self-checking bench for the fault mask editor top.
// Assumes the controller model drives the buttons; bench does bus and faults.
`timescale 1ns/1ps
`default_nettype none
module fmpe_top_tb;
    import fmpe_pkg::*;
    // ------------------------------------------------------------
    // Clock, reset, ports
    // ------------------------------------------------------------
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [BTN_N-1:0] btn_in;
    logic [FLT_N-1:0] fault_in = '0;
    logic fan_present_in = 1'b0;
    logic [FLT_N-1:0] led_fault;
    logic alarm_pa, alarm_temp, lcd_value, lcd_flash, lcd_error;
    logic [2:0] lcd_param;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    integer seed = 17808;
    logic [35:0] notes[$];
    logic [4:0] en = 5'h0F;
    logic pend = 1'b1;
    logic err = 1'b0;
    logic ku = 1'b0;
    int prm = 0;

    initial forever #5 core_clk = ~core_clk;

    fmpe_top #(.HOLD_CYC(20), .REP_CYC(5)) fmpe_top_inst (
        .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .btn_in(btn_in),
        .fault_in(fault_in), .fan_present_in(fan_present_in),
        .led_fault(led_fault), .alarm_pa(alarm_pa), .alarm_temp(alarm_temp),
        .lcd_param(lcd_param), .lcd_value(lcd_value),
        .lcd_flash(lcd_flash), .lcd_error(lcd_error));
    fmpe_hhc fmpe_hhc_inst (.core_clk(core_clk), .btn_in(btn_in));

    // ------------------------------------------------------------
    // Checking
    // ------------------------------------------------------------
    task automatic final_report();
        $display("Compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic cmp(input string nm, input logic [31:0] e, s);
        cmp_count++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask

    // Oldest note against each read answer; display pins ride along
    always @(posedge core_clk) begin
        logic [35:0] n;
        if (avs_read && avs_waitrequest === 1'b0 && notes.size() > 0) begin
            n = notes.pop_front();
            cmp("readdata", n[31:0], avs_readdata);
            if (n[35:32] == ADDR_STATUS)
                cmp("lcd", {26'h0, n[10:5]},
                    {26'h0, lcd_param, lcd_error, lcd_flash, lcd_value});
            if (n[35:32] == ADDR_FAULT) begin
                cmp("alarm", {30'h0, n[2], n[3]},
                    {30'h0, alarm_pa, alarm_temp});
                cmp("led", n[31:0], {27'h0, led_fault});
            end
        end
    end

    // Whole run needs about 930 cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 30000) begin
            err_total++;
            final_report();
        end
    end

    // ------------------------------------------------------------
    // Bus and button tasks
    // ------------------------------------------------------------
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d);
        int n;
        begin
            n = 0;
            @(posedge core_clk);
            avs_address <= a;
            avs_writedata <= d;
            avs_read <= ~wr;
            avs_write <= wr;
            do begin
                @(posedge core_clk);
                n++;
            end while (avs_waitrequest !== 1'b0 && n < 50);
            if (n >= 50) err_total++;
            avs_read <= 1'b0;
            avs_write <= 1'b0;
        end
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        notes.push_back({a, e});
        bus(1'b0, a, 32'h0);
    endtask

    function automatic logic [31:0] st();
        return {21'h0, 3'(prm), err, pend != en[prm], pend, en};
    endfunction

    function automatic logic [31:0] led();
        logic [4:0] f;
        f = fault_in;
        return {27'h0, ku ? f[4] & fan_present_in : f[4] & en[3] & en[1],
                f[3] & en[2] & en[1], f[2] & en[1], f[1] & en[0], f[0]};
    endfunction

    task automatic fn(input logic up, input int hold);
        fmpe_hhc_inst.press(up ? BTN_FN_UP : BTN_FN_DN, hold);
        prm = up ? (prm + 1) % 5 : (prm + 4) % 5;
        if (ku && prm == 3) prm = up ? 4 : 2;
        pend = en[prm];
        err = 1'b0;
        rd(ADDR_STATUS, st());
    endtask

    // A hold of 24 cycles gives exactly two steps with HOLD_CYC 20
    task automatic dt(input logic up, input int hold);
        fmpe_hhc_inst.press(up ? BTN_DT_UP : BTN_DT_DN, hold);
        if (hold == 3) pend = ~pend;
        err = 1'b0;
        rd(ADDR_STATUS, st());
    endtask

    task automatic ent();
        fmpe_hhc_inst.press(BTN_ENTER, 3);
        if (prm == 3 && pend && !en[1]) begin
            err = 1'b1;
            pend = en[3];
        end else begin
            en[prm] = pend;
            if (prm == 1 && !pend && !ku) en[3] = 1'b0;
        end
        rd(ADDR_STATUS, st());
    endtask

    task automatic flt(input int n);
        repeat (n) begin
            fault_in <= 5'($random(seed));
            fan_present_in <= 1'($random(seed));
            repeat (6) @(posedge core_clk);
            rd(ADDR_FAULT, led());
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(ADDR_STATUS, st());
        rd(ADDR_CTRL, 32'h0);
        rd(4'hC, 32'h0);
        bus(1'b1, ADDR_STATUS, 32'hFFFFFFFF);
        rd(ADDR_STATUS, st());
        flt(4);
        dt(1'b1, 3);
        dt(1'b0, 3);
        dt(1'b1, 3);
        ent();
        flt(3);
        repeat (5) fn(1'b1, 3);
        fn(1'b0, 3);
        dt(1'b1, 3);
        ent();
        dt(1'b1, 3);
        dt(1'b0, 3);
        fn(1'b1, 3);
        fn(1'b1, 3);
        dt(1'b1, 3);
        fn(1'b1, 3);
        fn(1'b0, 3);
        dt(1'b1, 3);
        ent();
        flt(4);
        fn(1'b1, 3);
        fn(1'b1, 3);
        dt(1'b1, 3);
        ent();
        dt(1'b1, 3);
        fn(1'b0, 3);
        fn(1'b0, 3);
        dt(1'b0, 3);
        ent();
        flt(3);
        dt(1'b1, 24);
        fn(1'b1, 24);
        fn(1'b0, 3);
        fn(1'b0, 3);
        bus(1'b1, ADDR_CTRL, 32'h1);
        ku = 1'b1;
        rd(ADDR_CTRL, 32'h1);
        fn(1'b0, 3);
        fn(1'b0, 3);
        fn(1'b1, 3);
        flt(6);
        fn(1'b1, 3);
        fn(1'b1, 3);
        dt(1'b1, 3);
        ent();
        flt(6);
        repeat (4) @(posedge core_clk);
        final_report();
    end
endmodule
`default_nettype wire
